// *** rtl/pwm_generator_deadband_core.sv ***
// one pwm generator: counter, comparators, dead band, event flags
// ==============================================================
// Behaviour
// - dead band delays first output's rise and the source's fall (second output's rise) by programmed ticks
// - dead band enabled makes second output derived from the first
// - dead band disabled makes both outputs independent again
// - writing the config word leaves the generator disabled
// - down mode counts load value to zero then reloads; left aligned
// - up/down mode counts zero to load and back; centre aligned
// - counter is 16 bits, counting down or up/down
// - period is ticks between successive zero events
// - sync mode holds new values until a sync event
// - immediate mode transfers new values without a sync event
// - new period and widths take effect only at counter zero
// - stop-on-halt counts to zero and holds there while halted
// - run-on-halt ignores a debugger halt
// - disabled generator counter does not advance
// - enabled generator counter advances each clock except with a zero load value or while stop-on-halt parks it at zero
// - six event flags, writing one clears a flag
// - writing one to the fault flag clears it
// - status readable raw and masked
// - enable set masks or unmasks each of the six event interrupts and triggers
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module pwm_generator_deadband_core (
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wr_data_i,
    input  wire logic        wr_en_i,
    input  wire logic        rd_en_i,
    output logic      [31:0] rd_data_o,
    input  wire logic        dbg_halt_i,
    input  wire logic        sync_i,
    input  wire logic        fault_i,
    output logic             gen_output_first_o,
    output logic             gen_output_second_o,
    output logic             irq_o,
    output logic             trig_o,
    output logic             fault_zero_irq_o
);
    // ==========================================================
    // pin synchronisers, [0] halt, [1] sync, [2] fault
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    logic       sync_prev_reg;

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            pin_meta_reg  <= 3'h0;
            pin_sync_reg  <= 3'h0;
            sync_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg  <= {fault_i, sync_i, dbg_halt_i};
            pin_sync_reg  <= pin_meta_reg;
            sync_prev_reg <= pin_sync_reg[1];
        end
    end

    // ==========================================================
    // register bus decode
    function automatic logic hit(input logic [7:0] off);
        hit = (addr_i == off);
    endfunction

    wire wr_cfg   = wr_en_i && hit(pwm_gen_pkg::OFF_CONFIG);
    wire wr_en    = wr_en_i && hit(pwm_gen_pkg::OFF_ENABLE);
    wire wr_dband = wr_en_i && hit(pwm_gen_pkg::OFF_DBAND);
    wire wr_rise  = wr_en_i && hit(pwm_gen_pkg::OFF_RISE);
    wire wr_fall  = wr_en_i && hit(pwm_gen_pkg::OFF_FALL);
    wire wr_load  = wr_en_i && hit(pwm_gen_pkg::OFF_LOAD);
    wire wr_cmpa  = wr_en_i && hit(pwm_gen_pkg::OFF_CMPA);
    wire wr_cmpb  = wr_en_i && hit(pwm_gen_pkg::OFF_CMPB);
    wire wr_sync  = wr_en_i && hit(pwm_gen_pkg::OFF_SYNC);
    wire wr_flags = wr_en_i && (hit(pwm_gen_pkg::OFF_RIS) ||
                                hit(pwm_gen_pkg::OFF_MIS));
    wire wr_inten = wr_en_i && hit(pwm_gen_pkg::OFF_INTEN);
    wire wr_fault = wr_en_i && hit(pwm_gen_pkg::OFF_FAULT);

    // ==========================================================
    // state
    logic [2:0]        cfg_reg;
    logic              en_reg;
    logic              db_en_reg;
    logic [15:0]       rise_reg;
    logic [15:0]       fall_reg;
    logic [15:0]       load_sh_reg, cmpa_sh_reg, cmpb_sh_reg;
    logic [15:0]       load_reg, cmpa_reg, cmpb_reg;
    logic              armed_reg;
    logic [13:0]       inten_reg;
    logic [5:0]        ris_reg;
    logic              fault_reg;
    logic [15:0]       cnt_reg;
    logic [15:0]       cnt_next;
    pwm_gen_pkg::dir_t dir_reg;
    pwm_gen_pkg::dir_t dir_next;
    logic              moved_reg;
    logic              a_raw_reg;
    logic              b_raw_reg;
    logic [31:0]       rd_mux;

    wire updown    = cfg_reg[pwm_gen_pkg::CFG_UPDOWN_BIT];
    wire sync_mode = cfg_reg[pwm_gen_pkg::CFG_SYNC_BIT];
    wire stop_mode = cfg_reg[pwm_gen_pkg::CFG_DBGSTOP_BIT];
    wire halt_s    = pin_sync_reg[0];
    wire fault_s   = pin_sync_reg[2];
    wire at_zero   = (cnt_reg == 16'h0000);

    // sync event from software or a rising edge on the shared pin
    wire sync_evt = (wr_sync && wr_data_i[0]) ||
                    (pin_sync_reg[1] && !sync_prev_reg);

    // shadows move to active set only at zero, gated by sync mode
    wire apply = at_zero && (!sync_mode || armed_reg);
    wire [15:0] load_new = apply ? load_sh_reg : load_reg;

    // halt parks the counter only once it has reached zero
    wire run = en_reg &&
               !(stop_mode && halt_s && at_zero);

    // ==========================================================
    // counter next state, 16 bit down or up/down
    always_comb begin
        cnt_next = cnt_reg;
        dir_next = dir_reg;
        if (run) begin
            if (!updown) begin
                // zero then reload: period load+1 ticks
                dir_next = pwm_gen_pkg::DIR_DOWN;
                cnt_next = at_zero ? load_new : cnt_reg - 16'h0001;
            end else if (at_zero) begin
                // turn upward at zero
                dir_next = (load_new != 16'h0000) ?
                           pwm_gen_pkg::DIR_UP : pwm_gen_pkg::DIR_DOWN;
                cnt_next = (load_new != 16'h0000) ? 16'h0001 : 16'h0000;
            end else if (dir_reg == pwm_gen_pkg::DIR_UP &&
                         cnt_reg >= load_reg) begin
                // top reached: turn down
                dir_next = pwm_gen_pkg::DIR_DOWN;
                cnt_next = cnt_reg - 16'h0001;
            end else begin
                cnt_next = (dir_reg == pwm_gen_pkg::DIR_UP) ?
                           cnt_reg + 16'h0001 : cnt_reg - 16'h0001;
            end
        end
    end

    // ==========================================================
    // events, only on cycles the counter has just moved to
    wire up_dir = (dir_reg == pwm_gen_pkg::DIR_UP);
    wire [5:0] evts = moved_reg ? {
        !up_dir && cnt_reg == cmpb_reg,
        up_dir  && cnt_reg == cmpb_reg,
        !up_dir && cnt_reg == cmpa_reg,
        up_dir  && cnt_reg == cmpa_reg,
        cnt_reg == load_reg,
        at_zero} : 6'h00;
    wire [5:0] flag_clr = wr_flags ? wr_data_i[5:0] : 6'h00;
    wire [5:0] masked   = ris_reg & inten_reg[5:0];

    // ==========================================================
    // configuration and enable
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            cfg_reg <= pwm_gen_pkg::RST_CONFIG;
            en_reg  <= 1'b0;
        end else begin
            if (wr_cfg)
                cfg_reg <= wr_data_i[2:0];
            // config write always parks the generator
            if (wr_cfg)
                en_reg <= 1'b0;
            else if (wr_en)
                en_reg <= wr_data_i[0];
        end
    end

    // dead band settings and shadow parameters
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            db_en_reg   <= 1'b0;
            rise_reg    <= pwm_gen_pkg::RST_VALUE;
            fall_reg    <= pwm_gen_pkg::RST_VALUE;
            load_sh_reg <= pwm_gen_pkg::RST_VALUE;
            cmpa_sh_reg <= pwm_gen_pkg::RST_VALUE;
            cmpb_sh_reg <= pwm_gen_pkg::RST_VALUE;
        end else begin
            if (wr_dband) db_en_reg   <= wr_data_i[0];
            if (wr_rise)  rise_reg    <= wr_data_i[15:0];
            if (wr_fall)  fall_reg    <= wr_data_i[15:0];
            if (wr_load)  load_sh_reg <= wr_data_i[15:0];
            if (wr_cmpa)  cmpa_sh_reg <= wr_data_i[15:0];
            if (wr_cmpb)  cmpb_sh_reg <= wr_data_i[15:0];
        end
    end

    // active parameters and sync arming; a new sync wins over use
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            load_reg  <= pwm_gen_pkg::RST_VALUE;
            cmpa_reg  <= pwm_gen_pkg::RST_VALUE;
            cmpb_reg  <= pwm_gen_pkg::RST_VALUE;
            armed_reg <= 1'b0;
        end else begin
            if (apply) begin
                load_reg <= load_sh_reg;
                cmpa_reg <= cmpa_sh_reg;
                cmpb_reg <= cmpb_sh_reg;
            end
            armed_reg <= sync_evt ||
                         (armed_reg && !(apply && sync_mode));
        end
    end

    // counter and comparator outputs
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            cnt_reg   <= pwm_gen_pkg::RST_VALUE;
            dir_reg   <= pwm_gen_pkg::DIR_DOWN;
            moved_reg <= 1'b0;
            a_raw_reg <= 1'b0;
            b_raw_reg <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            dir_reg   <= dir_next;
            moved_reg <= run;
            a_raw_reg <= en_reg && cnt_reg >= cmpa_reg;
            b_raw_reg <= en_reg && cnt_reg >= cmpb_reg;
        end
    end

    // flags: a new event beats a clear in the same cycle
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            ris_reg   <= pwm_gen_pkg::RST_FLAGS;
            inten_reg <= pwm_gen_pkg::RST_INTEN;
            fault_reg <= 1'b0;
            trig_o    <= 1'b0;
        end else begin
            ris_reg   <= evts | (ris_reg & ~flag_clr);
            if (wr_inten)
                inten_reg <= wr_data_i[13:0];
            fault_reg <= fault_s ||
                         (fault_reg && !(wr_fault && wr_data_i[0]));
            trig_o    <= |(evts &
                inten_reg[pwm_gen_pkg::TRIG_LSB +: 6]);
        end
    end

    assign irq_o            = |masked;
    assign fault_zero_irq_o = fault_reg;

    // ==========================================================
    // read path, unmapped offsets read zero
    assign rd_mux =
        hit(pwm_gen_pkg::OFF_CONFIG) ? {29'h0, cfg_reg} :
        hit(pwm_gen_pkg::OFF_ENABLE) ? {31'h0, en_reg} :
        hit(pwm_gen_pkg::OFF_DBAND)  ? {31'h0, db_en_reg} :
        hit(pwm_gen_pkg::OFF_RISE)   ? {16'h0, rise_reg} :
        hit(pwm_gen_pkg::OFF_FALL)   ? {16'h0, fall_reg} :
        hit(pwm_gen_pkg::OFF_LOAD)   ? {16'h0, load_sh_reg} :
        hit(pwm_gen_pkg::OFF_CMPA)   ? {16'h0, cmpa_sh_reg} :
        hit(pwm_gen_pkg::OFF_CMPB)   ? {16'h0, cmpb_sh_reg} :
        hit(pwm_gen_pkg::OFF_SYNC)   ? {31'h0, armed_reg} :
        hit(pwm_gen_pkg::OFF_RIS)    ? {26'h0, ris_reg} :
        hit(pwm_gen_pkg::OFF_INTEN)  ? {18'h0, inten_reg} :
        hit(pwm_gen_pkg::OFF_MIS)    ? {26'h0, masked} :
        hit(pwm_gen_pkg::OFF_COUNT)  ? {16'h0, cnt_reg} :
        hit(pwm_gen_pkg::OFF_FAULT)  ? {31'h0, fault_reg} : 32'h0;

    // data valid only in the cycle after the read strobe
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i)
            rd_data_o <= 32'h0;
        else
            rd_data_o <= rd_en_i ? rd_mux : 32'h0;
    end

    // ==========================================================
    // dead band pairing
    pwm_deadband u_dband (
        .core_clk_i          (core_clk_i),
        .resetn_i            (resetn_i),
        .db_en_i             (db_en_reg),
        .src_first_i         (a_raw_reg),
        .src_second_i        (b_raw_reg),
        .rise_edge_delay_i   (rise_reg),
        .fall_edge_delay_i   (fall_reg),
        .gen_output_first_o  (gen_output_first_o),
        .gen_output_second_o (gen_output_second_o)
    );

    // ==========================================================
    // assertions
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    a_cfg_disables: assert property (
        wr_cfg |=> !en_reg) else $error("config write left gen enabled");
    a_hold_disabled: assert property (
        !en_reg |=> $stable(cnt_reg)) else $error("counter moved while off");
    a_enabled_moves: assert property (
        en_reg && !halt_s && load_reg != 16'h0000 && !at_zero
        |=> cnt_reg != $past(cnt_reg)) else $error("counter stuck");
    a_down_reload: assert property (
        run && !updown && at_zero |=> cnt_reg == $past(load_new))
        else $error("down reload wrong");
    a_down_step: assert property (
        run && !updown && !at_zero |=> cnt_reg == $past(cnt_reg) - 16'h1)
        else $error("down step wrong");
    a_updown_turn: assert property (
        run && updown && up_dir && cnt_reg == load_reg && !at_zero
        |=> !up_dir ##1 (!up_dir || $past(at_zero)))
        else $error("no turn at top");
    a_update_zero: assert property (
        $changed(load_reg) |-> $past(at_zero)) else $error("update off zero");
    a_sync_hold: assert property (
        sync_mode && !armed_reg |=> $stable(load_reg))
        else $error("sync mode applied early");
    a_halt_park: assert property (
        stop_mode && halt_s && at_zero |=> $stable(cnt_reg) ##1 1'b1)
        else $error("halt did not park");
    a_flag_clear: assert property (
        wr_flags && wr_data_i[0] && !evts[0] |=> !ris_reg[0])
        else $error("flag not cleared");
    a_fault_clear: assert property (
        wr_fault && wr_data_i[0] && !fault_s |=> !fault_zero_irq_o)
        else $error("fault flag not cleared");
    a_no_overlap: assert property (
        db_en_reg && $past(db_en_reg) && $past(db_en_reg, 2)
        |-> !(gen_output_first_o && gen_output_second_o))
        else $error("dead band outputs overlap");

    c_updown_turn: cover property (run && updown && up_dir &&
        cnt_reg == load_reg && !at_zero);
    c_sync_apply: cover property (apply && sync_mode);
    c_halt_park: cover property (stop_mode && halt_s && at_zero && en_reg);
    c_dband_run: cover property (db_en_reg && gen_output_second_o);
endmodule

// *** rtl/pwm_gen_pkg.sv ***
// register map, field positions and reset values of the pwm generator
package pwm_gen_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] OFF_CONFIG = 8'h00;
    localparam logic [7:0] OFF_ENABLE = 8'h04;
    localparam logic [7:0] OFF_DBAND  = 8'h08;
    localparam logic [7:0] OFF_RISE   = 8'h0c;
    localparam logic [7:0] OFF_FALL   = 8'h10;
    localparam logic [7:0] OFF_LOAD   = 8'h14;
    localparam logic [7:0] OFF_CMPA   = 8'h18;
    localparam logic [7:0] OFF_CMPB   = 8'h1c;
    localparam logic [7:0] OFF_SYNC   = 8'h20;
    localparam logic [7:0] OFF_RIS    = 8'h24;
    localparam logic [7:0] OFF_INTEN  = 8'h28;
    localparam logic [7:0] OFF_MIS    = 8'h2c;
    localparam logic [7:0] OFF_COUNT  = 8'h30;
    localparam logic [7:0] OFF_FAULT  = 8'h34;
    // ==========================================================
    // config word fields
    localparam int CFG_UPDOWN_BIT  = 0;
    localparam int CFG_SYNC_BIT    = 1;
    localparam int CFG_DBGSTOP_BIT = 2;
    // event flag positions, trigger enables sit TRIG_LSB higher
    localparam int EVT_ZERO   = 0;
    localparam int EVT_LOAD   = 1;
    localparam int EVT_A_UP   = 2;
    localparam int EVT_A_DOWN = 3;
    localparam int EVT_B_UP   = 4;
    localparam int EVT_B_DOWN = 5;
    localparam int TRIG_LSB   = 8;
    // ==========================================================
    // reset values
    localparam logic [2:0]  RST_CONFIG = 3'h0;
    localparam logic [15:0] RST_VALUE  = 16'h0000;
    localparam logic [13:0] RST_INTEN  = 14'h0000;
    localparam logic [5:0]  RST_FLAGS  = 6'h00;
    // counting direction
    typedef enum logic {DIR_DOWN, DIR_UP} dir_t;
endpackage

// *** rtl/pwm_deadband.sv ***
// dead-band stage pairing the two generator outputs
`timescale 1ns/10ps
module pwm_deadband (
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        db_en_i,
    input  wire logic        src_first_i,
    input  wire logic        src_second_i,
    input  wire logic [15:0] rise_edge_delay_i,
    input  wire logic [15:0] fall_edge_delay_i,
    output logic             gen_output_first_o,
    output logic             gen_output_second_o
);
    // ==========================================================
    // edge age counters
    logic [15:0] hi_cnt_reg;
    logic [15:0] lo_cnt_reg;
    logic [15:0] hi_cnt_next;
    logic [15:0] lo_cnt_next;
    logic        first_next;
    logic        second_next;

    // saturate so a long steady level never wraps into a false edge
    assign hi_cnt_next = !src_first_i ? 16'h0000 :
        (hi_cnt_reg == 16'hffff) ? hi_cnt_reg : hi_cnt_reg + 16'h0001;
    assign lo_cnt_next = src_first_i ? 16'h0000 :
        (lo_cnt_reg == 16'hffff) ? lo_cnt_reg : lo_cnt_reg + 16'h0001;

    // first: delayed rise; second: inverted source, delayed rise
    assign first_next = db_en_i ?
        (src_first_i && hi_cnt_reg >= rise_edge_delay_i)
        : src_first_i;
    assign second_next = db_en_i ?
        (!src_first_i && lo_cnt_reg >= fall_edge_delay_i)
        : src_second_i;

    // output flops
    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            hi_cnt_reg          <= 16'h0000;
            lo_cnt_reg          <= 16'h0000;
            gen_output_first_o  <= 1'b0;
            gen_output_second_o <= 1'b0;
        end else begin
            hi_cnt_reg          <= hi_cnt_next;
            lo_cnt_reg          <= lo_cnt_next;
            gen_output_first_o  <= first_next;
            gen_output_second_o <= second_next;
        end
    end
endmodule

// *** tb/pwm_power_stage.sv ***
// model of the external power stage fed by the two gate drives
`timescale 1ns/10ps
module pwm_power_stage (
    input  wire logic core_clk_i,
    input  wire logic gate_high_i,
    input  wire logic gate_low_i,
    output int        shoot_cnt_o,
    output int        high_cnt_o,
    output int        low_cnt_o
);
    // ==========================================================
    // conduction tally; both switches on at once is shoot-through
    initial begin
        shoot_cnt_o = 0;
        high_cnt_o = 0;
        low_cnt_o = 0;
    end
    always @(posedge core_clk_i) begin
        shoot_cnt_o <= shoot_cnt_o + int'(gate_high_i & gate_low_i);
        high_cnt_o <= high_cnt_o + int'(gate_high_i);
        low_cnt_o <= low_cnt_o + int'(gate_low_i);
    end
endmodule

// *** tb/pwm_generator_deadband_core_tb.sv ***
// self-checking bench for one pwm generator with dead band
`timescale 1ns/10ps
module pwm_generator_deadband_core_tb;
    logic        core_clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wr_data_i = 32'h0000_0000;
    logic        wr_en_i = 1'b0;
    logic        rd_en_i = 1'b0;
    logic        dbg_halt_i = 1'b0;
    logic        fault_i = 1'b0;
    logic        sync_i = 1'b0;
    logic        trig_o;
    int          trig_n = 0;
    logic [31:0] rd_data_o;
    logic        first_o;
    logic        second_o;
    logic        irq_o;
    logic        fault_o;
    int          shoot;
    int          hi_a;
    int          hi_b;
    int          err_total = 0;
    int          total_checks = 0;
    int          cyc = 0;
    logic [31:0] d;
    logic [15:0] v [12];
    // ==========================================================
    // clock, design and power stage
    always #2 core_clk_i = ~core_clk_i;
    pwm_generator_deadband_core dut (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
        .rd_data_o(rd_data_o), .dbg_halt_i(dbg_halt_i), .sync_i(sync_i),
        .fault_i(fault_i), .gen_output_first_o(first_o),
        .gen_output_second_o(second_o), .irq_o(irq_o), .trig_o(trig_o),
        .fault_zero_irq_o(fault_o));
    pwm_power_stage stage (
        .core_clk_i(core_clk_i), .gate_high_i(first_o),
        .gate_low_i(second_o), .shoot_cnt_o(shoot), .high_cnt_o(hi_a),
        .low_cnt_o(hi_b));
    // trigger pulse tally, sampled like the power stage counts
    always @(posedge core_clk_i) trig_n <= trig_n + int'(trig_o);
    // ==========================================================
    // bus and compare helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge core_clk_i);
        addr_i <= a;
        wr_data_i <= w;
        wr_en_i <= 1'b1;
        @(posedge core_clk_i);
        wr_en_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_en_i <= 1'b1;
        @(posedge core_clk_i);
        rd_en_i <= 1'b0;
        #1 q = rd_data_o;
    endtask
    // back-to-back count reads, one sample per cycle
    task automatic burst();
        @(posedge core_clk_i);
        addr_i <= pwm_gen_pkg::OFF_COUNT;
        rd_en_i <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            @(posedge core_clk_i);
            if (i == 11) rd_en_i <= 1'b0;
            #1 v[i] = rd_data_o[15:0];
        end
    endtask
    // step check works from any phase, so no alignment is needed
    task automatic chk_seq(input logic ud);
        logic [15:0] e;
        for (int i = 2; i < 12; i++) begin
            if (!ud) e = (v[i-1] == 16'h0) ? 16'h3 : v[i-1] - 16'h1;
            else if (v[i-1] == 16'h3 || (v[i-1] != 16'h0 &&
                     v[i-2] > v[i-1])) e = v[i-1] - 16'h1;
            else e = v[i-1] + 16'h1;
            chk(32'(v[i]), 32'(e), "count step");
        end
    endtask
    task automatic chk_max(input logic [15:0] m);
        logic [15:0] top;
        top = 16'h0;
        foreach (v[i]) if (v[i] > top) top = v[i];
        chk(32'(top), 32'(m), "count peak");
    endtask
    // period is rewritten after every mode change
    task automatic setup(input logic [31:0] c, input logic [31:0] ld,
                         input logic [31:0] ca, input logic [31:0] cb);
        wr(pwm_gen_pkg::OFF_CONFIG, c);
        wr(pwm_gen_pkg::OFF_LOAD, ld);
        wr(pwm_gen_pkg::OFF_CMPA, ca);
        wr(pwm_gen_pkg::OFF_CMPB, cb);
        wr(pwm_gen_pkg::OFF_ENABLE, 32'h1);
    endtask
    // conduction over 64 cycles, eight whole periods of load 7
    task automatic win(input int s, input int a, input int b);
        int s0;
        int a0;
        int b0;
        int t0;
        repeat (20) @(posedge core_clk_i);
        #1 s0 = shoot;
        a0 = hi_a;
        b0 = hi_b;
        t0 = trig_n;
        repeat (64) @(posedge core_clk_i);
        #1 chk(32'(shoot - s0), 32'(s), "overlap");
        chk(32'(hi_a - a0), 32'(a), "first high");
        chk(32'(hi_b - b0), 32'(b), "second high");
        chk(32'(trig_n - t0), 32'h8, "zero triggers");
    endtask
    // ==========================================================
    // scenarios
    task automatic t_count();
        rd(8'hfc, d);
        chk(d, 32'h0, "unmapped");
        setup(32'h0, 32'h3, 32'h2, 32'h1);
        wr(pwm_gen_pkg::OFF_CONFIG, 32'h0);
        rd(pwm_gen_pkg::OFF_ENABLE, d);
        chk(d, 32'h0, "enable after config");
        burst();
        chk(32'(v[11]), 32'(v[0]), "frozen count");
        wr(pwm_gen_pkg::OFF_ENABLE, 32'h1);
        repeat (10) @(posedge core_clk_i);
        burst();
        chk_seq(1'b0);
        setup(32'h1, 32'h3, 32'h2, 32'h1);
        repeat (10) @(posedge core_clk_i);
        burst();
        chk_seq(1'b1);
    endtask
    task automatic t_events();
        setup(32'h0, 32'h3, 32'h2, 32'h1);
        repeat (12) @(posedge core_clk_i);
        wr(pwm_gen_pkg::OFF_RIS, 32'h3f);
        repeat (12) @(posedge core_clk_i);
        wr(pwm_gen_pkg::OFF_ENABLE, 32'h0);
        repeat (4) @(posedge core_clk_i);
        rd(pwm_gen_pkg::OFF_RIS, d);
        chk(d, 32'h2b, "raw flags");
        chk(32'(irq_o), 32'h0, "irq masked");
        rd(pwm_gen_pkg::OFF_MIS, d);
        chk(d, 32'h0, "masked none");
        wr(pwm_gen_pkg::OFF_INTEN, 32'h1);
        repeat (2) @(posedge core_clk_i);
        #1 chk(32'(irq_o), 32'h1, "irq on");
        rd(pwm_gen_pkg::OFF_MIS, d);
        chk(d, 32'h1, "masked zero");
        @(posedge core_clk_i);
        #1 chk(rd_data_o, 32'h0, "read data one cycle");
        wr(pwm_gen_pkg::OFF_RIS, 32'h3f);
        repeat (2) @(posedge core_clk_i);
        #1 chk(32'(irq_o), 32'h0, "irq off");
        rd(pwm_gen_pkg::OFF_RIS, d);
        chk(d, 32'h0, "flags cleared");
    endtask
    task automatic t_halt_sync();
        setup(32'h4, 32'h3, 32'h2, 32'h1);
        dbg_halt_i <= 1'b1;
        repeat (12) @(posedge core_clk_i);
        burst();
        chk(32'(v[0] | v[11]), 32'h0, "parked");
        dbg_halt_i <= 1'b0;
        setup(32'h0, 32'h3, 32'h2, 32'h1);
        dbg_halt_i <= 1'b1;
        repeat (10) @(posedge core_clk_i);
        burst();
        chk_seq(1'b0);
        dbg_halt_i <= 1'b0;
        setup(32'h2, 32'h3, 32'h2, 32'h1);
        wr(pwm_gen_pkg::OFF_SYNC, 32'h1);
        // let the pending sync be used up at a zero before new values
        repeat (8) @(posedge core_clk_i);
        rd(pwm_gen_pkg::OFF_SYNC, d);
        chk(d, 32'h0, "sync consumed");
        wr(pwm_gen_pkg::OFF_LOAD, 32'h5);
        repeat (20) @(posedge core_clk_i);
        burst();
        chk_max(16'h3);
        // second sync comes through the pin path
        sync_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        sync_i <= 1'b0;
        repeat (20) @(posedge core_clk_i);
        burst();
        chk_max(16'h5);
    endtask
    task automatic t_band_fault();
        setup(32'h0, 32'h7, 32'h4, 32'h4);
        wr(pwm_gen_pkg::OFF_INTEN, 32'h100); // trigger on zero only
        win(32, 32, 32);
        wr(pwm_gen_pkg::OFF_RISE, 32'h1);
        wr(pwm_gen_pkg::OFF_FALL, 32'h1);
        wr(pwm_gen_pkg::OFF_DBAND, 32'h1);
        win(0, 24, 24);
        fault_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        fault_i <= 1'b0;
        repeat (5) @(posedge core_clk_i);
        #1 chk(32'(fault_o), 32'h1, "fault set");
        wr(pwm_gen_pkg::OFF_FAULT, 32'h1);
        repeat (2) @(posedge core_clk_i);
        #1 chk(32'(fault_o), 32'h0, "fault cleared");
    endtask
    // ==========================================================
    // verdict, hang guard and main sequence
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            end_sim();
        end
    end
    initial begin
        repeat (10) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        t_count();
        t_events();
        t_halt_sync();
        t_band_fault();
        end_sim();
    end
endmodule
